/* File: src/fu_uart.sv */
// fu_uart: async serial port with fifos, threshold flags and bit compare
// assumes: register port on ref_clk, rx_pin asynchronous, pin mux outside
`timescale 1ns/10ps
`default_nettype none
module fu_uart (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic irq
);
  typedef struct packed {
    logic en;
    logic stop2;
    logic [1:0] wls;
    logic brk;
    logic odd;
    logic pe;
    logic sp;
    logic bme;
    logic abt_tx;
    logic abt_rx;
    logic lbk;
    logic bmie;
    logic pol;
    logic [3:0] rthr;
    logic [3:0] tthr;
    logic gie;
    logic [6:0] ien;
    logic [6:0] fl;
    logic [15:0] div;
    logic [7:0] rdata;
    logic [1:0] rxs;
    logic pin;
    fu_pkg::fu_phase_t txs;
    logic [15:0] tcnt;
    logic [7:0] tsh;
    logic [2:0] tbit;
    logic tstop;
    logic tpar;
    fu_pkg::fu_phase_t receive_active;
    logic [15:0] rcnt;
    logic [7:0] rsh;
    logic [2:0] rbit;
    logic rperr;
    logic [15:0] icnt;
    logic [7:0] ibits;
  } fu_state_t;

  fu_state_t s;
  fu_state_t n;
  logic tf_push, tf_pop, tf_clr, tf_full, tf_empty;
  logic rf_push, rf_pop, rf_clr, rf_full, rf_empty;
  logic [7:0] tf_head;
  logic [8:0] rf_head, rf_din;
  logic [3:0] tf_level, rf_level;
  logic tx_line, rx_in, ttick, rtick, itick, bm_ev, rx_rst, tx_rst, soft_rst;
  logic [7:0] rx_data;

  function automatic logic [2:0] last_bit(input logic [1:0] wls);
    last_bit = fu_pkg::WLS_LAST_BASE + {1'b0, wls};
  endfunction

  function automatic logic [7:0] data_mask(input logic [1:0] wls);
    data_mask = 8'hff >> (fu_pkg::BIT_LAST - last_bit(wls));
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wls,
                                   input logic odd, input logic sp);
    par_bit = sp ? 1'b1 : ((^(d & data_mask(wls))) ^ odd);
  endfunction

  fu_fifo #(.W(fu_pkg::BYTE_W), .DEPTH(fu_pkg::FIFO_DEPTH), .LW(fu_pkg::LEVEL_W)) u_txf (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .clr(tf_clr), .push(tf_push),
    .pop(tf_pop), .din(wdata), .head(tf_head), .level(tf_level),
    .full(tf_full), .empty(tf_empty)
  );

  fu_fifo #(.W(fu_pkg::BYTE_W + 1), .DEPTH(fu_pkg::FIFO_DEPTH), .LW(fu_pkg::LEVEL_W)) u_rxf (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .clr(rf_clr), .push(rf_push),
    .pop(rf_pop), .din(rf_din), .head(rf_head), .level(rf_level),
    .full(rf_full), .empty(rf_empty)
  );

  assign rdata = s.rdata;
  assign tx_pin = s.pin;
  assign irq = s.gie & ((|(s.fl & s.ien)) | (s.bme & s.bmie));

  // serial line level of the current transmit phase
  always_comb begin
    case (s.txs)
      fu_pkg::ST_START: tx_line = 1'b0;
      fu_pkg::ST_DATA: tx_line = s.tsh[0];
      fu_pkg::ST_PAR: tx_line = s.tpar;
      default: tx_line = 1'b1;
    endcase
  end

  assign rx_in = s.lbk ? tx_line : s.rxs[1];
  assign ttick = (s.tcnt == s.div - 16'h0001);
  assign rtick = (s.rcnt == s.div - 16'h0001);
  assign itick = (s.icnt == s.div - 16'h0001);
  assign rx_data = (s.rsh >> (fu_pkg::BIT_LAST - last_bit(s.wls)));

  always_comb begin
    n = s;
    n.rdata = fu_pkg::RST_BYTE;
    n.rxs = {s.rxs[0], rx_pin};
    tf_push = 1'b0;
    tf_pop = 1'b0;
    rf_push = 1'b0;
    rf_pop = 1'b0;
    rf_din = {s.rperr & s.pe, rx_data};
    bm_ev = 1'b0;
    rx_rst = 1'b0;
    tx_rst = 1'b0;
    soft_rst = (s.div == '0) && !s.en;
    // register reads
    if (rd) begin
      case (addr)
        fu_pkg::A_FRAME: n.rdata = {s.en, s.stop2, s.wls, s.brk, s.odd, rf_head[8], s.sp};
        fu_pkg::A_EXT: n.rdata = {s.receive_active != fu_pkg::ST_IDLE, s.bme, s.abt_tx, s.abt_rx,
                                  s.lbk, s.bmie, 1'b0, s.pol};
        fu_pkg::A_FIFO: n.rdata = {rf_level, tf_level};
        fu_pkg::A_DATA: begin
          n.rdata = rf_head[7:0];
          rf_pop = 1'b1;
          if (rf_empty) begin
            n.fl[fu_pkg::B_RFU] = 1'b1;
          end
        end
        fu_pkg::A_INT: n.rdata = {s.gie, s.fl};
        fu_pkg::A_DIVL: n.rdata = s.div[7:0];
        fu_pkg::A_DIVH: n.rdata = s.div[15:8];
        default: n.rdata = fu_pkg::RST_BYTE;
      endcase
    end
    // register writes
    if (wr) begin
      case (addr)
        fu_pkg::A_FRAME: begin
          n.en = wdata[fu_pkg::B_EN];
          n.stop2 = wdata[fu_pkg::B_STOP2];
          n.wls = wdata[fu_pkg::B_WLS+:2];
          n.brk = wdata[fu_pkg::B_BRK];
          n.odd = wdata[fu_pkg::B_ODD];
          n.pe = wdata[fu_pkg::B_PE];
          n.sp = wdata[fu_pkg::B_SP];
        end
        fu_pkg::A_EXT: begin
          n.bme = s.bme & wdata[fu_pkg::B_BME];
          n.abt_tx = wdata[fu_pkg::B_ABTX];
          n.abt_rx = wdata[fu_pkg::B_ABRX];
          n.lbk = wdata[fu_pkg::B_LBK];
          n.bmie = wdata[fu_pkg::B_BMIE];
          n.pol = wdata[fu_pkg::B_POL];
          if (wdata[fu_pkg::B_CLR]) begin
            rx_rst = 1'b1;
            tx_rst = 1'b1;
          end
        end
        fu_pkg::A_FIFO: begin
          n.rthr = wdata[fu_pkg::B_RTHR+:4];
          n.tthr = wdata[fu_pkg::B_TTHR+:4];
          rx_rst = rx_rst | (wdata[fu_pkg::B_RTHR+:4] == fu_pkg::RX_THR_RESET);
          tx_rst = tx_rst | (wdata[fu_pkg::B_TTHR+:4] == fu_pkg::TX_THR_RESET);
        end
        fu_pkg::A_DATA: begin
          tf_push = 1'b1;
          if (tf_full) begin
            n.fl[fu_pkg::B_TFO] = 1'b1;
          end
        end
        fu_pkg::A_INT: begin
          n.gie = wdata[fu_pkg::B_GIE];
          n.ien = wdata[6:0];
          for (int i = 0; i < fu_pkg::B_RDA; i++) begin
            if (!wdata[i]) begin
              n.fl[i] = 1'b0;
            end
          end
          if (!wdata[fu_pkg::B_RDA] && (rf_level < s.rthr)) begin
            n.fl[fu_pkg::B_RDA] = 1'b0;
          end
        end
        fu_pkg::A_DIVL: n.div[7:0] = wdata;
        fu_pkg::A_DIVH: n.div[15:8] = wdata;
        default: ;
      endcase
    end
    // transmit engine
    n.tcnt = ttick ? '0 : s.tcnt + 16'h0001;
    case (s.txs)
      fu_pkg::ST_IDLE: begin
        n.tcnt = '0;
        if (s.en && !tf_empty) begin
          tf_pop = 1'b1;
          n.tsh = tf_head;
          n.tpar = par_bit(tf_head, s.wls, s.odd, s.sp);
          n.txs = fu_pkg::ST_START;
        end
      end
      fu_pkg::ST_START: begin
        if (ttick) begin
          n.txs = fu_pkg::ST_DATA;
          n.tbit = '0;
        end
      end
      fu_pkg::ST_DATA: begin
        if (ttick) begin
          n.tsh = {1'b0, s.tsh[7:1]};
          n.tbit = s.tbit + 3'h1;
          n.tstop = 1'b0;
          if (s.tbit == last_bit(s.wls)) begin
            n.txs = s.pe ? fu_pkg::ST_PAR : fu_pkg::ST_STOP;
          end
        end
      end
      fu_pkg::ST_PAR: begin
        if (ttick) begin
          n.txs = fu_pkg::ST_STOP;
        end
      end
      fu_pkg::ST_STOP: begin
        if (ttick) begin
          if (s.stop2 && !s.tstop) begin
            n.tstop = 1'b1;
          end else begin
            n.txs = fu_pkg::ST_IDLE;
            if (tf_empty) begin
              n.fl[fu_pkg::B_TI] = 1'b1;
            end
          end
        end
      end
      default: n.txs = fu_pkg::ST_IDLE;
    endcase
    // sent bit against line, mid bit
    if (s.txs != fu_pkg::ST_IDLE && s.tcnt == (s.div >> 1) && rx_in != tx_line) begin
      bm_ev = 1'b1;
      n.bme = 1'b1;
    end
    // receive engine
    n.rcnt = rtick ? '0 : s.rcnt + 16'h0001;
    case (s.receive_active)
      fu_pkg::ST_IDLE: begin
        n.rcnt = '0;
        if (s.en && !rx_in) begin
          n.receive_active = fu_pkg::ST_START;
        end
      end
      fu_pkg::ST_START: begin
        if (s.rcnt == (s.div >> 1)) begin
          n.rcnt = '0;
          n.rbit = '0;
          n.rperr = 1'b0;
          n.receive_active = rx_in ? fu_pkg::ST_IDLE : fu_pkg::ST_DATA;
        end
      end
      fu_pkg::ST_DATA: begin
        if (rtick) begin
          n.rsh = {rx_in, s.rsh[7:1]};
          n.rbit = s.rbit + 3'h1;
          if (s.rbit == last_bit(s.wls)) begin
            n.receive_active = s.pe ? fu_pkg::ST_PAR : fu_pkg::ST_STOP;
          end
        end
      end
      fu_pkg::ST_PAR: begin
        if (rtick) begin
          n.rperr = (rx_in != par_bit(rx_data, s.wls, s.odd, s.sp));
          n.receive_active = fu_pkg::ST_STOP;
        end
      end
      fu_pkg::ST_STOP: begin
        if (rtick) begin
          n.receive_active = fu_pkg::ST_IDLE;
          rf_push = 1'b1;
          if (!rx_in) begin
            n.fl[fu_pkg::B_FRAMING_ERROR] = 1'b1;
          end
          if (rf_full) begin
            n.fl[fu_pkg::B_RFO] = 1'b1;
          end
        end
      end
      default: n.receive_active = fu_pkg::ST_IDLE;
    endcase
    // idle line time in bit periods
    if (s.receive_active == fu_pkg::ST_IDLE && rx_in) begin
      n.icnt = itick ? '0 : s.icnt + 16'h0001;
      if (itick && s.ibits != fu_pkg::IDLE_SAT) begin
        n.ibits = s.ibits + 8'h01;
      end
    end else begin
      n.icnt = '0;
      n.ibits = '0;
    end
    // aborts, flushes and disable
    rx_rst = rx_rst | soft_rst | (bm_ev & s.abt_rx);
    tx_rst = tx_rst | soft_rst | (bm_ev & s.abt_tx);
    if (rx_rst || !s.en) begin
      n.receive_active = fu_pkg::ST_IDLE;
    end
    if (tx_rst || !s.en) begin
      n.txs = fu_pkg::ST_IDLE;
    end
    if (rx_rst) begin
      n.fl[fu_pkg::B_RFO] = 1'b0;
      n.fl[fu_pkg::B_RFU] = 1'b0;
    end
    if (tx_rst) begin
      n.fl[fu_pkg::B_TFO] = 1'b0;
    end
    rf_clr = rx_rst;
    tf_clr = tx_rst;
    // level flags
    n.fl[fu_pkg::B_TRA] = (tf_level < s.tthr);
    if ((rf_level > s.rthr && s.rthr != fu_pkg::RX_THR_RESET) ||
        (rf_level != '0 && rf_level < s.rthr &&
         s.ibits > 8'(s.rthr) * fu_pkg::IDLE_MULT)) begin
      n.fl[fu_pkg::B_RDA] = 1'b1;
    end
    // output pin
    n.pin = s.brk ? 1'b0 : (tx_line ^ s.pol);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
      s.txs <= fu_pkg::ST_IDLE;
      s.receive_active <= fu_pkg::ST_IDLE;
      s.rxs <= 2'b11;
      s.pin <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end
endmodule // fu_uart
`default_nettype wire

/* File: inc/fu_pkg.sv */
// fu_pkg: register map, field positions and phase codes of the fifo uart
// assumes: byte-wide register port, one system clock
package fu_pkg;
  localparam logic [7:0] A_FRAME = 8'hb1;
  localparam logic [7:0] A_EXT = 8'hb2;
  localparam logic [7:0] A_FIFO = 8'hb3;
  localparam logic [7:0] A_DATA = 8'hb4;
  localparam logic [7:0] A_INT = 8'hb5;
  localparam logic [7:0] A_DIVL = 8'hb6;
  localparam logic [7:0] A_DIVH = 8'hb7;
  localparam int FIFO_DEPTH = 15;
  localparam int LEVEL_W = 4;
  localparam int DIV_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // serial_frame_config
  localparam int B_EN = 7;
  localparam int B_STOP2 = 6;
  localparam int B_WLS = 4;
  localparam int B_BRK = 3;
  localparam int B_ODD = 2;
  localparam int B_PE = 1;
  localparam int B_SP = 0;
  // serial_extended_config
  localparam int B_RECEIVE_ACTIVE = 7;
  localparam int B_BME = 6;
  localparam int B_ABTX = 5;
  localparam int B_ABRX = 4;
  localparam int B_LBK = 3;
  localparam int B_BMIE = 2;
  localparam int B_CLR = 1;
  localparam int B_POL = 0;
  // fifo_level_threshold
  localparam int B_RTHR = 4;
  localparam int B_TTHR = 0;
  // interrupt_flags_enables
  localparam int B_GIE = 7;
  localparam int B_TRA = 6;
  localparam int B_RDA = 5;
  localparam int B_RFO = 4;
  localparam int B_RFU = 3;
  localparam int B_TFO = 2;
  localparam int B_FRAMING_ERROR = 1;
  localparam int B_TI = 0;
  localparam logic [3:0] RX_THR_RESET = 4'hf;
  localparam logic [3:0] TX_THR_RESET = 4'h0;
  localparam logic [7:0] IDLE_MULT = 8'h10;
  localparam logic [7:0] IDLE_SAT = 8'hff;
  localparam logic [2:0] WLS_LAST_BASE = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PAR = 5'h08,
    ST_STOP = 5'h10
  } fu_phase_t;
endpackage

/* File: src/fu_fifo.sv */
// fu_fifo: flip-flop fifo with level count
// assumes: same clock and clock enable as the uart core
`timescale 1ns/10ps
`default_nettype none
module fu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 15,
  parameter int LW = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] din,
  output logic [W-1:0] head,
  output logic [LW-1:0] level,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LW-1:0] wp;
    logic [LW-1:0] rp;
    logic [LW-1:0] cnt;
  } fu_fifo_st_t;
  localparam logic [LW-1:0] LAST = LW'(DEPTH - 1);
  localparam logic [LW-1:0] ONE = LW'(1);
  fu_fifo_st_t s;
  fu_fifo_st_t n;
  logic do_push;
  logic do_pop;

  assign head = s.mem[s.rp];
  assign level = s.cnt;
  assign full = (s.cnt == LW'(DEPTH));
  assign empty = (s.cnt == '0);

  always_comb begin
    n = s;
    do_push = push & ~full;
    do_pop = pop & ~empty;
    if (do_push) begin
      n.mem[s.wp] = din;
      n.wp = (s.wp == LAST) ? '0 : s.wp + ONE;
    end
    if (do_pop) begin
      n.rp = (s.rp == LAST) ? '0 : s.rp + ONE;
    end
    if (do_push && !do_pop) begin
      n.cnt = s.cnt + ONE;
    end else if (do_pop && !do_push) begin
      n.cnt = s.cnt - ONE;
    end
    if (clr) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
endmodule // fu_fifo
`default_nettype wire

/* File: verif/fu_uart_chk.sv */
// fu_uart_chk: port level assertions for the fifo uart
// assumes: bound to fu_uart; shadows follow the register port writes
`timescale 1ns/10ps
`default_nettype none
module fu_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_pin,
  input wire logic irq
);
  logic [7:0] frm;
  logic [7:0] ext;
  logic [7:0] ien;
  logic [7:0] dvl;
  logic [7:0] dvh;
  logic [3:0] tthr;
  logic quiet;
  assign quiet = !frm[fu_pkg::B_EN] && !frm[fu_pkg::B_BRK];
  // shadows of the write-side register fields
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frm <= 8'h00;
      ext <= 8'h00;
      ien <= 8'h00;
      dvl <= 8'h00;
      dvh <= 8'h00;
      tthr <= 4'h0;
    end else if (wr && ce) begin
      case (addr)
        fu_pkg::A_FRAME: frm <= wdata;
        fu_pkg::A_EXT: ext <= wdata;
        fu_pkg::A_FIFO: tthr <= wdata[3:0];
        fu_pkg::A_INT: ien <= wdata;
        fu_pkg::A_DIVL: dvl <= wdata;
        fu_pkg::A_DIVH: dvh <= wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_frame_rb;
    $past(rd) && $past(addr) == fu_pkg::A_FRAME |-> (rdata & 8'hfd) == ($past(frm) & 8'hfd);
  endproperty
  a_frame_rb: assert property (p_frame_rb) else $error("frame config readback wrong");
  property p_ext_rb;
    $past(rd) && $past(addr) == fu_pkg::A_EXT |-> (rdata & 8'h3f) == ($past(ext) & 8'h3d);
  endproperty
  a_ext_rb: assert property (p_ext_rb) else $error("extended config readback wrong");
  property p_div_lo;
    $past(rd) && $past(addr) == fu_pkg::A_DIVL |-> rdata == $past(dvl);
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("divisor low readback wrong");
  property p_div_hi;
    $past(rd) && $past(addr) == fu_pkg::A_DIVH |-> rdata == $past(dvh);
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("divisor high readback wrong");
  property p_irq_gate;
    irq |-> ien[fu_pkg::B_GIE] && (ien[6:0] != 7'h00 || ext[fu_pkg::B_BMIE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
  property p_break;
    frm[fu_pkg::B_BRK] && $past(frm[fu_pkg::B_BRK]) && $past(frm[fu_pkg::B_BRK], 2) |-> !tx_pin;
  endproperty
  a_break: assert property (p_break) else $error("break not holding line low");
  property p_idle;
    quiet && $past(quiet) && $past(quiet, 2) && $stable(ext[0]) && $past(ext[0], 2) == ext[0]
      |-> tx_pin == !ext[fu_pkg::B_POL];
  endproperty
  a_idle: assert property (p_idle) else $error("disabled port line not idle");
  property p_tra_zero;
    $past(rd) && $past(addr) == fu_pkg::A_INT && $past(tthr) == 4'h0 |-> !rdata[fu_pkg::B_TRA];
  endproperty
  a_tra_zero: assert property (p_tra_zero) else $error("tx ready with zero threshold");
  c_irq: cover property ($rose(irq));
  c_brk: cover property (frm[fu_pkg::B_BRK] ##3 !tx_pin);
  c_data_rd: cover property (rd && addr == fu_pkg::A_DATA);
endmodule // fu_chk
bind fu_uart fu_chk u_chk (.ref_clk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .tx_pin, .irq);
`default_nettype wire

/* File: verif/fu_node.sv */
// fu_node: remote serial node, sends frames on rx_pin, captures tx_pin
// assumes: idle high line, bit time of div clocks, no echo of own frames
`timescale 1ns/10ps
`default_nettype none
module fu_node (
  input wire logic ref_clk,
  input wire logic tx_pin,
  input wire logic [15:0] div,
  input wire logic [3:0] nbits,
  output logic rx_pin
);
  logic [15:0] got_q[$];
  int t_q[$];
  initial rx_pin = 1'b1;
  // capture start time, data bits and the slot after them
  always begin : capture
    logic [15:0] w;
    @(negedge tx_pin);
    t_q.push_back(int'($time / 100));
    w = 16'h0000;
    repeat (div >> 1) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (div) @(posedge ref_clk);
      w[i] = tx_pin;
    end
    got_q.push_back(w);
  end
  // one frame, lsb first; pb below zero means no parity bit
  task automatic send(input logic [7:0] d, input int n, input int pb, input logic stp);
    @(posedge ref_clk);
    rx_pin <= 1'b0;
    repeat (div) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx_pin <= d[i];
      repeat (div) @(posedge ref_clk);
    end
    if (pb >= 0) begin
      rx_pin <= pb[0];
      repeat (div) @(posedge ref_clk);
    end
    rx_pin <= stp;
    repeat (div) @(posedge ref_clk);
    rx_pin <= 1'b1;
  endtask
endmodule // fu_node
`default_nettype wire

/* File: verif/fu_uart_tb_top.sv */
// fu_uart_tb_top: register level tests of the fifo uart with a remote node
// assumes: 10 MHz ref_clk, divisor 4, ce held high
`timescale 1ns/10ps
`default_nettype none
module fu_uart_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rx_pin;
  logic tx_pin;
  logic irq;
  logic [15:0] ndiv = 16'h0004;
  logic [3:0] nbits = 4'h9;
  logic [7:0] d;
  logic [15:0] e;
  logic pb;
  int n;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [7:0] CFG [4] = '{8'h80, 8'h92, 8'ha6, 8'hf7};
  always #50 ref_clk = ~ref_clk;
  fu_uart dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  fu_node node (.ref_clk(ref_clk), .tx_pin(tx_pin), .div(ndiv), .nbits(nbits), .rx_pin(rx_pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(16'(rdata & m), 16'(x));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int a = 8'hb0; a < 8'hb9; a++) rchk(8'(a), 8'hff, 8'h00);
    wr_reg(fu_pkg::A_DIVL, 8'h04);
    wr_reg(fu_pkg::A_DIVH, 8'h00);
    wr_reg(fu_pkg::A_FIFO, 8'h0f);
    rchk(fu_pkg::A_DIVL, 8'hff, 8'h04);
    for (int c = 0; c < 4; c++) begin
      n = 5 + c;
      nbits <= 4'(n + 1);
      wr_reg(fu_pkg::A_FRAME, CFG[c]);
      node.got_q.delete();
      node.t_q.delete();
      wr_reg(fu_pkg::A_DATA, 8'hd3);
      wr_reg(fu_pkg::A_DATA, 8'h2c);
      for (int i = 0; i < 3000 && node.got_q.size() < 2; i++) @(posedge ref_clk);
      repeat (14) @(posedge ref_clk);
      for (int k = 0; k < 2; k++) begin
        d = (k == 0 ? 8'hd3 : 8'h2c) & (8'hff >> (8 - n));
        pb = (c == 1) ? ^d : ((c == 2) ? ~^d : 1'b1);
        e = 16'(d) | (16'(pb) << n);
        chk(node.got_q[k], e);
      end
      chk(16'(node.t_q[1] - node.t_q[0]), 16'((2 + n + (c > 0) + (c == 3)) * 4 + 1));
    end
    rchk(fu_pkg::A_INT, 8'h41, 8'h41);
    wr_reg(fu_pkg::A_INT, 8'h01);
    #1 chk(16'(irq), 16'h0000);
    wr_reg(fu_pkg::A_INT, 8'h81);
    #1 chk(16'(irq), 16'h0001);
    wr_reg(fu_pkg::A_INT, 8'h80);
    #1 chk(16'(irq), 16'h0000);
    rchk(fu_pkg::A_INT, 8'h01, 8'h00);
    $display("test tx frames and irq finished");
    rchk(fu_pkg::A_EXT, 8'h40, 8'h40);
    wr_reg(fu_pkg::A_FRAME, 8'h30);
    for (int i = 0; i < 3; i++) wr_reg(fu_pkg::A_DATA, 8'h55);
    rchk(fu_pkg::A_FIFO, 8'h0f, 8'h03);
    wr_reg(fu_pkg::A_EXT, 8'h20);
    rchk(fu_pkg::A_EXT, 8'h40, 8'h00);
    wr_reg(fu_pkg::A_FRAME, 8'hb0);
    repeat (12) @(posedge ref_clk);
    rchk(fu_pkg::A_FIFO, 8'h0f, 8'h00);
    rchk(fu_pkg::A_EXT, 8'h40, 8'h40);
    wr_reg(fu_pkg::A_EXT, 8'h00);
    wr_reg(fu_pkg::A_FRAME, 8'h30);
    for (int i = 0; i < 16; i++) wr_reg(fu_pkg::A_DATA, 8'(i));
    rchk(fu_pkg::A_FIFO, 8'h0f, 8'h0f);
    rchk(fu_pkg::A_INT, 8'h44, 8'h04);
    wr_reg(fu_pkg::A_INT, 8'h00);
    rchk(fu_pkg::A_INT, 8'h04, 8'h00);
    wr_reg(fu_pkg::A_EXT, 8'h02);
    rchk(fu_pkg::A_FIFO, 8'h0f, 8'h00);
    wr_reg(fu_pkg::A_DATA, 8'h11);
    wr_reg(fu_pkg::A_FIFO, 8'h00);
    rchk(fu_pkg::A_FIFO, 8'h0f, 8'h00);
    $display("test mismatch and fifo finished");
    wr_reg(fu_pkg::A_FIFO, 8'h0f);
    wr_reg(fu_pkg::A_FRAME, 8'hb0);
    fork
      node.send(8'h5a, 8, -1, 1'b1);
      begin
        repeat (20) @(posedge ref_clk);
        rchk(fu_pkg::A_EXT, 8'h80, 8'h80);
      end
    join
    repeat (6) @(posedge ref_clk);
    rchk(fu_pkg::A_EXT, 8'h80, 8'h00);
    rchk(fu_pkg::A_INT, 8'h20, 8'h20);
    rchk(fu_pkg::A_FIFO, 8'hf0, 8'h10);
    rchk(fu_pkg::A_DATA, 8'hff, 8'h5a);
    rchk(fu_pkg::A_DATA, 8'h00, 8'h00);
    rchk(fu_pkg::A_FIFO, 8'hf0, 8'h00);
    rchk(fu_pkg::A_INT, 8'h08, 8'h08);
    wr_reg(fu_pkg::A_FRAME, 8'hb2);
    node.send(8'h01, 8, 0, 1'b1);
    repeat (6) @(posedge ref_clk);
    rchk(fu_pkg::A_FRAME, 8'h02, 8'h02);
    node.send(8'h03, 8, 0, 1'b0);
    repeat (6) @(posedge ref_clk);
    rchk(fu_pkg::A_INT, 8'h02, 8'h02);
    wr_reg(fu_pkg::A_INT, 8'h00);
    rchk(fu_pkg::A_INT, 8'h02, 8'h00);
    wr_reg(fu_pkg::A_FIFO, 8'hf0);
    rchk(fu_pkg::A_FIFO, 8'hf0, 8'h00);
    wr_reg(fu_pkg::A_FIFO, 8'h2f);
    wr_reg(fu_pkg::A_INT, 8'h00);
    wr_reg(fu_pkg::A_FRAME, 8'hb0);
    node.send(8'h77, 8, -1, 1'b1);
    repeat (6) @(posedge ref_clk);
    rchk(fu_pkg::A_INT, 8'h20, 8'h00);
    repeat (160) @(posedge ref_clk);
    rchk(fu_pkg::A_INT, 8'h20, 8'h20);
    wr_reg(fu_pkg::A_FIFO, 8'h0f);
    wr_reg(fu_pkg::A_INT, 8'h00);
    rchk(fu_pkg::A_INT, 8'h20, 8'h20);
    rchk(fu_pkg::A_DATA, 8'hff, 8'h77);
    wr_reg(fu_pkg::A_EXT, 8'h08);
    wr_reg(fu_pkg::A_DATA, 8'hc5);
    repeat (60) @(posedge ref_clk);
    rchk(fu_pkg::A_DATA, 8'hff, 8'hc5);
    $display("test receive finished");
    wr_reg(fu_pkg::A_EXT, 8'h00);
    wr_reg(fu_pkg::A_FRAME, 8'h08);
    repeat (3) @(posedge ref_clk);
    #1 chk(16'(tx_pin), 16'h0000);
    wr_reg(fu_pkg::A_FRAME, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1 chk(16'(tx_pin), 16'h0001);
    wr_reg(fu_pkg::A_EXT, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1 chk(16'(tx_pin), 16'h0000);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rchk(fu_pkg::A_DIVL, 8'hff, 8'h00);
    $display("test line levels finished");
    results();
  end
endmodule // fu_uart_tb_top
`default_nettype wire
